//--- hdl/atpwm_pkg.sv
package atpwm_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_TCS  = 8'h0D;
  localparam logic [7:0] ADDR_CNTH = 8'h0E;
  localparam logic [7:0] ADDR_CNTL = 8'h0F;
  localparam logic [7:0] ADDR_RLDH = 8'h10;
  localparam logic [7:0] ADDR_RLDL = 8'h11;
  localparam logic [7:0] ADDR_PCR  = 8'h12;
  localparam logic [7:0] ADDR_PSR  = 8'h13;
  localparam logic [7:0] ADDR_DTYH = 8'h17;
  localparam logic [7:0] ADDR_DTYL = 8'h18;

  // Field positions
  localparam int TCS_CK_LSB = 3;
  localparam int TCS_CK_W   = 2;
  localparam int TCS_OVF    = 2;
  localparam int TCS_OVERFLOW_IRQ_ENABLE  = 1;
  localparam int TCS_COMPARE_IRQ_ENABLE  = 0;
  localparam int PSR_POL    = 1;
  localparam int PSR_CMPF   = 0;
  localparam int PCR_EN     = 0;
  localparam int CNT_W      = 12;
  localparam int LO_W       = 8;
  localparam int HI_W       = CNT_W - LO_W;

  // Reset and fixed values
  localparam logic [7:0]       REG_RST = 8'h00;
  localparam logic [HI_W-1:0]  HI_PAD  = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;

  // Counter clock select codes, in field order
  typedef enum logic [1:0] {
    CKS_OFF,
    CKS_LITE,
    CKS_CPU,
    CKS_RSVD
  } atpwm_cks_t;

endpackage

//--- hdl/atpwm_tick_if.sv
`timescale 1ns/1ns
interface atpwm_tick_if;
  logic [1:0] sel;
  logic       tick;
  modport src (input sel, output tick);
  modport dst (output sel, input tick);
endinterface

//--- hdl/atpwm_clk_sel.sv
`timescale 1ns/1ns
module atpwm_clk_sel
  import atpwm_pkg::*;
(
  // Clock and reset
  input wire logic     mclk,
  input wire logic     rst_b,
  // Timebase from the lite timer
  input wire logic     lite_timebase_clock,
  // Counter clock enable
  atpwm_tick_if.src    tk
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic tick;
  } atpwm_cs_t;

  atpwm_cs_t s;
  atpwm_cs_t next_s;

  always_comb begin
    next_s       = s;
    next_s.sync1 = lite_timebase_clock;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
    // Reserved code falls through to off
    case (atpwm_cks_t'(tk.sel))
      CKS_LITE: next_s.tick = s.sync2 && !s.prev;
      CKS_CPU:  next_s.tick = 1'b1;
      default:  next_s.tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tk.tick = s.tick;

endmodule // atpwm_clk_sel

//--- hdl/atpwm_top.sv
`timescale 1ns/1ns
// Overview of operation
// - Clock select 00 stops counter, 01 lite timebase, 10 CPU clock, 11 reserved.
// - Overflow flag set at max-to-reload; cleared by status read, writes ignored.
// - Overflow flag stays set for at least one counter clock cycle.
// - Overflow interrupt enable gates overflow request; read/write, reset clears.
// - Compare interrupt enable masks compare request; reset clears.
// - 12-bit counter increments per counter clock; high byte upper bits read zero.
// - Each overflow loads the reload value into the counter.
// - Counter resets to zero and is read-only.
// - Reload value sets counter period and PWM frequency.
// - Pin enable set uses duty as PWM duty; clear uses it as compare target.
// - Polarity bit passes PWM unchanged at 0, inverted at 1.
// - Compare flag set on counter match; cleared by PWM status read.
// - Pin enable 0 releases pin; 1 drives PWM onto it.
// - PWM goes high on overflow, low on duty match, before polarity.
// - PWM duty is preloaded and transferred to active duty at overflow.
// - Duty high write suspends compare until duty low write.
// - Compare mode loads duty immediately; no compare while value is zero.
module atpwm_top
  import atpwm_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Timebase from the lite timer
  input  wire logic       lite_timebase_clock,
  // PWM pin
  output logic            pwm_output,
  output logic            pwm_output_oe,
  // Interrupt requests
  output logic            ovf_irq,
  output logic            cmp_irq
);

  typedef struct packed {
    logic [1:0]       cks;
    logic             ovf;
    logic             ovf_hold;
    logic             ovf_ie;
    logic             cmp_ie;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] rld;
    logic             pin_en;
    logic             pol;
    logic             cmpf;
    logic [HI_W-1:0]  duty_hi;
    logic [LO_W-1:0]  duty_lo;
    logic [CNT_W-1:0] shadow;
    logic             lock;
    logic             pwm_lvl;
    logic             pwm_pin;
    logic [7:0]       rdata;
  } atpwm_state_t;

  atpwm_state_t     s;
  atpwm_state_t     next_s;
  logic             ovf_ev;
  logic             match;
  logic [CNT_W-1:0] duty;
  logic [CNT_W-1:0] target;
  logic [CNT_W-1:0] cnt_inc;

  atpwm_tick_if tk ();

  atpwm_clk_sel u_clk_sel (
    .mclk                (mclk),
    .rst_b               (rst_b),
    .lite_timebase_clock (lite_timebase_clock),
    .tk                  (tk.src)
  );

  assign tk.sel = s.cks;

  always_comb begin
    duty    = {s.duty_hi, s.duty_lo};
    // Compare mode sees the written value at once, PWM only the shadow
    target  = s.pin_en ? s.shadow : duty;
    cnt_inc = s.cnt + CNT_ONE;
    ovf_ev  = tk.tick && (s.cnt == CNT_MAX);
    match   = tk.tick && !ovf_ev && !s.lock && (cnt_inc == target)
              && (s.pin_en || (target != CNT_RST));
  end

  always_comb begin
    next_s          = s;
    next_s.rdata    = REG_RST;
    next_s.ovf_hold = s.ovf_hold && !tk.tick;

    // Reads: value before any clear; reserved bits stay zero
    if (reg_rd) begin
      if (reg_addr == ADDR_TCS) begin
        next_s.rdata[TCS_CK_LSB +: TCS_CK_W] = s.cks;
        next_s.rdata[TCS_OVF]                = s.ovf;
        next_s.rdata[TCS_OVERFLOW_IRQ_ENABLE]              = s.ovf_ie;
        next_s.rdata[TCS_COMPARE_IRQ_ENABLE]              = s.cmp_ie;
        if (!s.ovf_hold) begin
          next_s.ovf = 1'b0;
        end
      end else if (reg_addr == ADDR_CNTH) begin
        next_s.rdata = {HI_PAD, s.cnt[CNT_W-1:LO_W]};
      end else if (reg_addr == ADDR_CNTL) begin
        next_s.rdata = s.cnt[LO_W-1:0];
      end else if (reg_addr == ADDR_RLDH) begin
        next_s.rdata = {HI_PAD, s.rld[CNT_W-1:LO_W]};
      end else if (reg_addr == ADDR_RLDL) begin
        next_s.rdata = s.rld[LO_W-1:0];
      end else if (reg_addr == ADDR_PCR) begin
        next_s.rdata[PCR_EN] = s.pin_en;
      end else if (reg_addr == ADDR_PSR) begin
        next_s.rdata[PSR_POL]  = s.pol;
        next_s.rdata[PSR_CMPF] = s.cmpf;
        next_s.cmpf            = 1'b0;
      end else if (reg_addr == ADDR_DTYH) begin
        next_s.rdata = {HI_PAD, s.duty_hi};
      end else if (reg_addr == ADDR_DTYL) begin
        next_s.rdata = s.duty_lo;
      end
    end

    // Writes: flags and counter are not writable
    if (reg_wr) begin
      if (reg_addr == ADDR_TCS) begin
        next_s.cks    = reg_wdata[TCS_CK_LSB +: TCS_CK_W];
        next_s.ovf_ie = reg_wdata[TCS_OVERFLOW_IRQ_ENABLE];
        next_s.cmp_ie = reg_wdata[TCS_COMPARE_IRQ_ENABLE];
      end else if (reg_addr == ADDR_RLDH) begin
        next_s.rld[CNT_W-1:LO_W] = reg_wdata[HI_W-1:0];
      end else if (reg_addr == ADDR_RLDL) begin
        next_s.rld[LO_W-1:0] = reg_wdata;
      end else if (reg_addr == ADDR_PCR) begin
        next_s.pin_en = reg_wdata[PCR_EN];
      end else if (reg_addr == ADDR_PSR) begin
        next_s.pol = reg_wdata[PSR_POL];
      end else if (reg_addr == ADDR_DTYH) begin
        next_s.duty_hi = reg_wdata[HI_W-1:0];
        next_s.lock    = 1'b1;
      end else if (reg_addr == ADDR_DTYL) begin
        next_s.duty_lo = reg_wdata;
        next_s.lock    = 1'b0;
      end
    end

    // Counting; hardware sets come last so they beat a clearing read
    if (ovf_ev) begin
      next_s.cnt      = s.rld;
      next_s.ovf      = 1'b1;
      next_s.ovf_hold = 1'b1;
      // Half-written duty is taken as is, like the old shadow behaviour
      next_s.shadow   = duty;
      next_s.pwm_lvl  = 1'b1;
    end else if (tk.tick) begin
      next_s.cnt = cnt_inc;
    end
    if (match) begin
      next_s.cmpf = 1'b1;
      if (s.pin_en) begin
        next_s.pwm_lvl = 1'b0;
      end
    end

    // Pin low while released so the pad sees no stale level
    next_s.pwm_pin = next_s.pin_en && (next_s.pwm_lvl ^ next_s.pol);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata     = s.rdata;
  assign pwm_output    = s.pwm_pin;
  assign pwm_output_oe = s.pin_en;
  assign ovf_irq       = s.ovf && s.ovf_ie;
  assign cmp_irq       = s.cmpf && s.cmp_ie;

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!rst_b);

  property p_cks_off;
    ((s.cks == CKS_OFF) || (s.cks == CKS_RSVD)) [*2] |=> $stable(s.cnt);
  endproperty
  a_cks_off: assert property (p_cks_off)
    else $error("Counter moved with clock off");

  property p_cpu_count;
    (s.cks == CKS_CPU) [*2] ##0 (s.cnt != CNT_MAX)
      |=> (s.cnt == ($past(s.cnt) + CNT_ONE));
  endproperty
  a_cpu_count: assert property (p_cpu_count)
    else $error("Counter did not advance on CPU clock");

  property p_reload;
    ovf_ev |=> (s.cnt == $past(s.rld)) && s.ovf;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Overflow did not reload counter");

  property p_ovf_rdclr;
    reg_rd && (reg_addr == ADDR_TCS) && !s.ovf_hold && !ovf_ev |=> !s.ovf;
  endproperty
  a_ovf_rdclr: assert property (p_ovf_rdclr)
    else $error("Status read did not clear overflow flag");

  property p_ovf_hold;
    s.ovf_hold |=> s.ovf;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("Overflow flag dropped within its counter cycle");

  property p_ovf_ie_off;
    reg_wr && (reg_addr == ADDR_TCS) && !reg_wdata[TCS_OVERFLOW_IRQ_ENABLE] |=> !ovf_irq ##1 1'b1;
  endproperty
  a_ovf_ie_off: assert property (p_ovf_ie_off)
    else $error("Overflow request with enable cleared");

  property p_cmp_ie_off;
    reg_wr && (reg_addr == ADDR_TCS) && !reg_wdata[TCS_COMPARE_IRQ_ENABLE] |=> !cmp_irq;
  endproperty
  a_cmp_ie_off: assert property (p_cmp_ie_off)
    else $error("Compare request with enable cleared");

  property p_pwm_high;
    ovf_ev && s.pin_en && !reg_wr |=> (pwm_output == !s.pol) && pwm_output_oe;
  endproperty
  a_pwm_high: assert property (p_pwm_high)
    else $error("PWM not at active level after overflow");

  property p_pin_release;
    reg_wr && (reg_addr == ADDR_PCR) && !reg_wdata[PCR_EN]
      |=> !pwm_output_oe && !pwm_output;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("Pin still driven after release");

  property p_lock;
    s.lock && !s.cmpf |=> !s.cmpf;
  endproperty
  a_lock: assert property (p_lock)
    else $error("Compare fired while duty update incomplete");

  property p_oc_zero;
    !s.pin_en && (duty == CNT_RST) && !s.cmpf |=> !s.cmpf;
  endproperty
  a_oc_zero: assert property (p_oc_zero)
    else $error("Compare fired on zero compare value");

  property p_shadow;
    ovf_ev |=> (s.shadow == $past(duty));
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("Shadow duty not loaded at overflow");

  property p_pwm_match;
    match && s.pin_en |=> s.cmpf && !s.pwm_lvl;
  endproperty
  a_pwm_match: assert property (p_pwm_match)
    else $error("Duty match did not drop PWM and set flag");

  property p_cnth_pad;
    reg_rd && (reg_addr == ADDR_CNTH) |=> (reg_rdata[7:HI_W] == HI_PAD);
  endproperty
  a_cnth_pad: assert property (p_cnth_pad)
    else $error("Counter high byte upper bits not zero");

  property p_rd_once;
    !reg_rd |=> (reg_rdata == REG_RST);
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("Read data outside read answer cycle");

  property p_ovf_wr;
    reg_wr && !reg_rd && (reg_addr == ADDR_TCS) && !ovf_ev |=> (s.ovf == $past(s.ovf));
  endproperty
  a_ovf_wr: assert property (p_ovf_wr)
    else $error("Write changed overflow flag");

  property p_cmpf_rdclr;
    reg_rd && (reg_addr == ADDR_PSR) && !match |=> !s.cmpf;
  endproperty
  a_cmpf_rdclr: assert property (p_cmpf_rdclr)
    else $error("Status read did not clear compare flag");

  property p_cnt_ro;
    reg_wr && ((reg_addr == ADDR_CNTH) || (reg_addr == ADDR_CNTL)) && !tk.tick
      |=> $stable(s.cnt);
  endproperty
  a_cnt_ro: assert property (p_cnt_ro)
    else $error("Counter took a software write");

  property p_rld_wr;
    reg_wr && (reg_addr == ADDR_RLDL) |=> (s.rld[LO_W-1:0] == $past(reg_wdata));
  endproperty
  a_rld_wr: assert property (p_rld_wr)
    else $error("Reload low byte not written");

  property p_oc_load;
    reg_wr && (reg_addr == ADDR_DTYL) && !s.pin_en
      |=> (target == {$past(s.duty_hi), $past(reg_wdata)});
  endproperty
  a_oc_load: assert property (p_oc_load)
    else $error("Compare target not loaded at once");

  property p_oc_match;
    match && !s.pin_en |=> s.cmpf;
  endproperty
  a_oc_match: assert property (p_oc_match)
    else $error("Compare match did not set flag");

  property p_lock_set;
    reg_wr && (reg_addr == ADDR_DTYH) |=> s.lock;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("Duty high write did not suspend compare");

  property p_shadow_hold;
    !ovf_ev |=> $stable(s.shadow);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("Shadow duty changed outside overflow");

  c_overflow:   cover property (ovf_ev);
  c_pwm_cycle:  cover property (ovf_ev && s.pin_en ##[1:300] match);
  c_oc_match:   cover property (match && !s.pin_en);
  c_ovf_clear:  cover property (s.ovf ##1 (reg_rd && (reg_addr == ADDR_TCS)) ##1 !s.ovf);
  c_duty_lock:  cover property (s.lock && tk.tick);

endmodule // atpwm_top

//--- tb/atpwm_pin_load.sv
`timescale 1ns/1ns
module atpwm_pin_load (
  // Clock and window control
  input  wire logic        mclk,
  input  wire logic        clr,
  // Pin as seen from the board
  input  wire logic        pin_data,
  input  wire logic        pin_oe,
  // Cycles seen high since the last clear
  output logic      [15:0] high_cnt
);
  logic pin;

  // A released pin falls to the board pull-down, never the last driven level
  assign pin = pin_oe ? pin_data : 1'b0;

  always_ff @(posedge mclk) begin
    if (clr) begin
      high_cnt <= 16'h0000;
    end else begin
      high_cnt <= high_cnt + {15'h0000, pin};
    end
  end
endmodule // atpwm_pin_load

//--- tb/tb_autoreload_timer_pwm.sv
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_autoreload_timer_pwm;
  import atpwm_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} atpwm_row_t;

  logic        mclk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        lite;
  logic        pwm_output;
  logic        pwm_output_oe;
  logic        ovf_irq;
  logic        cmp_irq;
  logic        clr;
  logic [15:0] high_cnt;
  int          miscompares = 0;
  int          check_count = 0;

  localparam atpwm_row_t ROWS [10] = '{
    '{ADDR_TCS, 8'hFB, 8'h1B}, '{ADDR_CNTH, 8'hFF, 8'h00}, '{ADDR_CNTL, 8'hFF, 8'h00},
    '{ADDR_RLDH, 8'hFF, 8'h0F}, '{ADDR_RLDL, 8'hA5, 8'hA5}, '{ADDR_PCR, 8'hFF, 8'h01},
    '{ADDR_PSR, 8'hFF, 8'h02}, '{ADDR_DTYH, 8'hFF, 8'h0F}, '{ADDR_DTYL, 8'h5A, 8'h5A},
    '{8'h14, 8'hFF, 8'h00}};

  atpwm_top uut (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lite_timebase_clock(lite), .pwm_output(pwm_output), .pwm_output_oe(pwm_output_oe),
    .ovf_irq(ovf_irq), .cmp_irq(cmp_irq));

  atpwm_pin_load load (
    .mclk(mclk), .clr(clr), .pin_data(pwm_output), .pin_oe(pwm_output_oe),
    .high_cnt(high_cnt));

  always #50 mclk = ~mclk;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // Bounded wait on one of the request lines
  task automatic wait_for(input bit on_cmp);
    int n = 0;
    while ((on_cmp ? cmp_irq : ovf_irq) !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(on_cmp ? cmp_irq : ovf_irq, 1'b1)
  endtask

  // High cycles over four whole periods of 16 counts
  task automatic meas(input logic [15:0] e);
    repeat (20) @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (64) @(posedge mclk);
    #1;
    `CHK(high_cnt, e)
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    miscompares++;
    wrap_up();
  end

  initial begin
    {mclk, rst_b, reg_addr, reg_wdata, reg_wr, reg_rd, lite, clr} = '0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (ROWS[i]) begin
      rdc(ROWS[i].a, REG_RST);
      wr(ROWS[i].a, ROWS[i].d);
      rdc(ROWS[i].a, ROWS[i].e);
    end
    $display("register table done");
    wr(ADDR_TCS, 8'h08);
    repeat (5) begin
      repeat (4) @(posedge mclk);
      lite <= 1'b1;
      repeat (4) @(posedge mclk);
      lite <= 1'b0;
    end
    repeat (10) @(posedge mclk);
    wr(ADDR_TCS, 8'h18);
    repeat (10) @(posedge mclk);
    rdc(ADDR_CNTL, 8'h05);
    rdc(ADDR_CNTH, 8'h00);
    $display("timebase count done");
    wr(ADDR_RLDH, 8'h0F);
    wr(ADDR_RLDL, 8'hF0);
    wr(ADDR_DTYH, 8'h0F);
    wr(ADDR_DTYL, 8'hFC);
    wr(ADDR_PSR, 8'h00);
    wr(ADDR_TCS, 8'h12);
    wait_for(1'b0);
    rdc(ADDR_TCS, 8'h16);
    rdc(ADDR_TCS, 8'h12);
    `CHK(ovf_irq, 1'b0)
    meas(16'h0030);
    `CHK(cmp_irq, 1'b0)
    wr(ADDR_PSR, 8'h02);
    meas(16'h0010);
    wr(ADDR_PCR, 8'h00);
    meas(16'h0000);
    `CHK({pwm_output_oe, pwm_output}, 2'h0)
    $display("pwm done");
    wr(ADDR_TCS, 8'h11);
    wr(ADDR_DTYH, 8'h00);
    wr(ADDR_DTYL, 8'h00);
    rdc(ADDR_PSR, 8'h03);
    repeat (40) @(posedge mclk);
    rdc(ADDR_PSR, 8'h02);
    wr(ADDR_DTYH, 8'h0F);
    wr(ADDR_DTYL, 8'hF8);
    wait_for(1'b1);
    rdc(ADDR_PSR, 8'h03);
    rdc(ADDR_PSR, 8'h02);
    `CHK(cmp_irq, 1'b0)
    wr(ADDR_DTYH, 8'h0F);
    rdc(ADDR_PSR, 8'h02);
    repeat (40) @(posedge mclk);
    rdc(ADDR_PSR, 8'h02);
    wr(ADDR_DTYL, 8'hF8);
    wait_for(1'b1);
    $display("compare done");
    // Reset in mid-run with the counter going and a request pending
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK({ovf_irq, cmp_irq, pwm_output_oe, pwm_output}, 4'h0)
    rst_b <= 1'b1;
    rdc(ADDR_TCS, REG_RST);
    rdc(ADDR_CNTL, REG_RST);
    rdc(ADDR_PSR, REG_RST);
    $display("reset done");
    wrap_up();
  end
endmodule // tb_autoreload_timer_pwm
